// file: logic/sar_link_pkg.sv
// Package of constants and types shared by the converter and host ends
package sar_link_pkg;
	// ==========================================
	// Widths and counts
	localparam int          RESULT_W      = 8;       // Result width in bits
	localparam int          MUX_BITS      = 2;       // Assignment bits on two-channel variant
	localparam logic [3:0]  LAST_BIT_IDX  = 4'h7;    // Index of last result bit
	localparam logic [1:0]  LAST_MUX_IDX  = 2'h1;    // Index of last assignment bit
	localparam logic        START_BIT_VAL = 1'b1;    // Level that marks a start bit
	localparam logic        SGL_MODE      = 1'b1;    // Single-ended when first bit is 1
	localparam logic        DIFF_MODE     = 1'b0;    // Differential when first bit is 0
	localparam logic [7:0]  RESULT_ZERO   = 8'h00;   // Clamped result for negative input
	localparam int          MIN_CYCLE_1CH = 11;      // Least link periods per cycle, one channel
	localparam int          MIN_CYCLE_2CH = 13;      // Least link periods per cycle, two channels
	localparam logic [4:0]  HALF_DIV      = 5'h03;   // Last divider count of a serial clock half period (four host clocks)
	localparam logic [4:0]  GAP_HALVES    = 5'h02;   // Host half periods with select high

	// ==========================================
	// Converter sequencer states
	typedef enum logic [2:0] {
		DEV_IDLE   = 3'b000,   // Deselected, low power
		DEV_WAIT   = 3'b001,   // Waiting for start bit
		DEV_ADDR   = 3'b010,   // Taking assignment bits
		DEV_SETTLE = 3'b011,   // Settling period, leading zero
		DEV_MSB    = 3'b100,   // MSB-first result bits
		DEV_LSB    = 3'b101,   // LSB-first result bits
		DEV_DONE   = 3'b110    // Output held low
	} dev_state_e;

	// Host sequencer states
	typedef enum logic [2:0] {
		HST_IDLE  = 3'b000,   // Select high
		HST_START = 3'b001,   // Presenting start bit
		HST_MUX   = 3'b010,   // Presenting assignment bits
		HST_READ  = 3'b011,   // Collecting result bits
		HST_GAP   = 3'b100    // Select high between cycles
	} hst_state_e;
endpackage

// file: logic/sar_link_if.sv
// Interface carrying the four-wire serial link between host and converter
`timescale 1ns/10ps
interface sar_link_if;
	logic sclk;          // Serial clock from host
	logic sel_n;         // Active-low select from host
	logic serial_in_line; // Host to converter data
	logic dout_o;        // Converter output value
	logic dout_oe;       // Converter output enable
	logic dout_line;     // Resolved output wire, 1'b1 when released

	// Resolved wire: a released line reads high (pull-up)
	assign dout_line = dout_oe ? dout_o : 1'b1;

	modport device (input sclk, input sel_n, input serial_in_line,
		output dout_o, output dout_oe);
	modport host (output sclk, output sel_n, output serial_in_line,
		input dout_line, input dout_oe);
endinterface

// file: logic/sar_adc_seq.sv
// Converter end: serial sequencer of the successive-approximation converter
`timescale 1ns/10ps
// Overview of operation
// - Host holds select low through readout
// - Sample input on rising serial clock edges
// - First one on input is start bit
// - Two assignment bits follow start bit
// - First bit mode, second bit channel/polarity
// - Single-channel variant takes no assignment bits
// - Half-clock settling, then input ignored
// - Output released during settling, drives zero from its ending fall
// - Result bits on falling edge, MSB first
// - Conversion takes eight clock periods
// - Two-channel variant repeats result LSB first
// - Output low after last bit until deselect
// - Negative input difference gives all zeros
// - Deselected: output released, logic static
// - New assignment accepted every conversion
// - Input sampled only while output released
// - Eleven periods least per one-channel cycle
module sar_adc_seq
	import sar_link_pkg::*;
#(
	parameter bit TWO_CHANNEL = 1'b1   // 1: two-channel variant, 0: single channel
) (
	// System
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          clk_en,
	// Link
	sar_link_if.device                         link,
	// Analog stand-ins: digitised channel 0 and channel 1 inputs
	input  wire logic [sar_link_pkg::RESULT_W-1:0] ch0_level,
	input  wire logic [sar_link_pkg::RESULT_W-1:0] ch1_level,
	// Status to user side
	output logic                               busy,
	output logic [sar_link_pkg::RESULT_W-1:0]  last_result,
	output logic [sar_link_pkg::MUX_BITS-1:0]  mux_cfg
);
	import sar_link_pkg::*;

	// ==========================================
	// State
	typedef struct packed {
		dev_state_e        st;         // Sequencer state
		logic              sclk_d;     // Previous serial clock for edge detect
		logic [1:0]        addr_sr;    // Multiplexer address shift register
		logic [1:0]        addr_cnt;   // Assignment bits taken
		logic [3:0]        bit_cnt;    // Result bit counter
		logic [7:0]        approximation_register; // Result being built
		logic [7:0]        out_sr;     // LSB-first output shift register
		logic [7:0]        diff;       // Clamped input difference
		logic              dout;       // Output value
		logic              oe;         // Output enable
		logic [7:0]        result;     // Last finished result
	} dev_s;

	dev_s r_r;     // Registered state
	dev_s r_nxt;   // Next state

	logic rise;    // Serial clock rising edge
	logic fall;    // Serial clock falling edge
	logic [7:0] pos_v;  // Selected positive input
	logic [7:0] neg_v;  // Selected negative input

	// Edge detect on the host-made serial clock
	assign rise = link.sclk & ~r_r.sclk_d;
	assign fall = ~link.sclk & r_r.sclk_d;

	// Input pair from assignment; mode bit sits in addr_sr[1]
	always_comb begin
		pos_v = ch0_level;
		neg_v = ch1_level;
		if (TWO_CHANNEL && r_r.addr_sr[1] == SGL_MODE) begin
			pos_v = r_r.addr_sr[0] ? ch1_level : ch0_level;
			neg_v = RESULT_ZERO;
		end else if (TWO_CHANNEL && r_r.addr_sr[0]) begin
			pos_v = ch1_level;
			neg_v = ch0_level;
		end
	end

	// ==========================================
	// Next-state logic
	always_comb begin
		r_nxt = r_r;
		r_nxt.sclk_d = link.sclk;
		if (link.sel_n) begin
			// Abort and clear state, counters, address, shift and output registers while deselected
			r_nxt.st       = DEV_IDLE;
			r_nxt.addr_sr  = 2'h0;
			r_nxt.addr_cnt = 2'h0;
			r_nxt.bit_cnt  = 4'h0;
			r_nxt.out_sr   = 8'h00;
			r_nxt.oe       = 1'b0;
			r_nxt.dout     = 1'b0;
		end else begin
			unique case (r_r.st)
				DEV_IDLE: begin
					r_nxt.st = DEV_WAIT;
				end
				DEV_WAIT: begin
					// Leading zeros are dropped until a one arrives
					if (rise && link.serial_in_line == START_BIT_VAL) begin
						r_nxt.addr_cnt = 2'h0;
						r_nxt.st = TWO_CHANNEL ? DEV_ADDR : DEV_SETTLE;
					end
				end
				DEV_ADDR: begin
					// Shift in the fresh assignment of this conversion
					if (rise) begin
						r_nxt.addr_sr  = {r_r.addr_sr[0], link.serial_in_line};
						r_nxt.addr_cnt = r_r.addr_cnt + 2'h1;
						if (r_r.addr_cnt == LAST_MUX_IDX) begin
							r_nxt.st = DEV_SETTLE;
						end
					end
				end
				DEV_SETTLE: begin
					// Half period later the output leaves high impedance with a zero
					if (fall) begin
						r_nxt.oe   = 1'b1;
						r_nxt.dout = 1'b0;
						r_nxt.diff = (pos_v < neg_v) ? RESULT_ZERO : pos_v - neg_v;
						r_nxt.approximation_register = 8'h00;
						r_nxt.bit_cnt = 4'h0;
						r_nxt.st = DEV_MSB;
					end
				end
				DEV_MSB: begin
					// One comparison per period, driven on the falling edge
					if (fall) begin
						r_nxt.dout = r_r.diff[3'(LAST_BIT_IDX - r_r.bit_cnt)];
						r_nxt.approximation_register =
							{r_r.approximation_register[6:0],
							 r_r.diff[3'(LAST_BIT_IDX - r_r.bit_cnt)]};
						r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
						if (r_r.bit_cnt == LAST_BIT_IDX) begin
							r_nxt.result = r_r.diff;
							r_nxt.out_sr = {1'b0, r_r.diff[7:1]};
							r_nxt.bit_cnt = 4'h0;
							r_nxt.st = TWO_CHANNEL ? DEV_LSB : DEV_DONE;
						end
					end
				end
				DEV_LSB: begin
					// Bit 0 already went out last period; continue from bit 1
					if (fall) begin
						r_nxt.dout   = r_r.out_sr[0];
						r_nxt.out_sr = {1'b0, r_r.out_sr[7:1]};
						r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
						if (r_r.bit_cnt == 4'(LAST_BIT_IDX - 4'h1)) begin
							r_nxt.st = DEV_DONE;
						end
					end
				end
				DEV_DONE: begin
					// Hold low until deselected
					if (fall) begin
						r_nxt.dout = 1'b0;
					end
				end
				default: begin
					r_nxt.st = DEV_IDLE;
				end
			endcase
		end
	end

	// State register with clock enable
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r_r <= '{st: DEV_IDLE, default: '0};
		end else if (clk_en) begin
			r_r <= r_nxt;
		end
	end

	// ==========================================
	// Outputs
	assign link.dout_o  = r_r.dout;
	assign link.dout_oe = r_r.oe;
	assign busy         = (r_r.st != DEV_IDLE) && (r_r.st != DEV_WAIT);
	assign last_result  = r_r.result;
	assign mux_cfg      = r_r.addr_sr;
endmodule

// file: logic/sar_host_ctrl.sv
// Host end: drives select, serial clock and assignment, collects the result
`timescale 1ns/10ps
module sar_host_ctrl
	import sar_link_pkg::*;
#(
	parameter bit TWO_CHANNEL = 1'b1   // Must match the converter variant
) (
	// System
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          clk_en,
	// Request
	input  wire logic                          req_valid,
	input  wire logic [sar_link_pkg::MUX_BITS-1:0] req_mux,
	output logic                               req_ready,
	// Answer
	output logic                               rsp_valid,
	output logic [sar_link_pkg::RESULT_W-1:0]  rsp_msb,
	output logic [sar_link_pkg::RESULT_W-1:0]  rsp_lsb,
	// Link
	sar_link_if.host                           link
);
	import sar_link_pkg::*;

	// ==========================================
	// State
	typedef struct packed {
		hst_state_e st;        // Sequencer state
		logic [4:0] div;       // Half-period divider
		logic       sclk;      // Serial clock out
		logic       sel_n;     // Select out
		logic       din;       // Data out
		logic [1:0] mux;       // Latched assignment
		logic [1:0] mcnt;      // Assignment bits sent
		logic [4:0] rcnt;      // Rising edges made while reading
		logic [7:0] msb;       // MSB-first collection
		logic [7:0] lsb;       // LSB-first collection
		logic       done;      // Answer pulse
	} hst_s;

	hst_s r_r;     // Registered state
	hst_s r_nxt;   // Next state

	logic tick;    // End of a half period
	assign tick = (r_r.div == HALF_DIV);

	// ==========================================
	// Next-state logic
	always_comb begin
		r_nxt = r_r;
		r_nxt.done = 1'b0;
		if (r_r.st != HST_IDLE) begin
			r_nxt.div = tick ? 5'h00 : r_r.div + 5'h01;
		end
		unique case (r_r.st)
			HST_IDLE: begin
				if (req_valid) begin
					// Select low starts the cycle; held low through readout
					r_nxt.sel_n = 1'b0;
					r_nxt.sclk  = 1'b0;
					r_nxt.din   = START_BIT_VAL;
					r_nxt.mux   = req_mux;
					r_nxt.div   = 5'h00;
					r_nxt.mcnt  = 2'h0;
					r_nxt.rcnt  = 5'h00;
					r_nxt.st    = HST_START;
				end
			end
			HST_START, HST_MUX: begin
				if (tick) begin
					r_nxt.sclk = ~r_r.sclk;
					// After the rising edge, set up the next bit on the fall
					if (r_r.sclk) begin
						if (TWO_CHANNEL && r_r.mcnt != 2'(MUX_BITS)) begin
							r_nxt.din  = r_r.mux[1 - r_r.mcnt[0]];
							r_nxt.mcnt = r_r.mcnt + 2'h1;
							r_nxt.st   = HST_MUX;
						end else begin
							// Line released to the converter from here
							r_nxt.din = 1'b0;
							r_nxt.st  = HST_READ;
						end
					end
				end
			end
			HST_READ: begin
				if (tick) begin
					r_nxt.sclk = ~r_r.sclk;
					// Sample output just before each rising edge; the one at rcnt 0 sees the leading zero and is dropped
					if (!r_r.sclk) begin
						if (r_r.rcnt != 5'h00 && r_r.rcnt <= 5'h08) begin
							r_nxt.msb = {r_r.msb[6:0], link.dout_line};
						end else if (r_r.rcnt > 5'h08) begin
							r_nxt.lsb = {link.dout_line, r_r.lsb[7:1]};
						end
						r_nxt.rcnt = r_r.rcnt + 5'h01;
						if (r_r.rcnt == (TWO_CHANNEL ? 5'h10 : 5'h08)) begin
							// Two-channel: bit 0 is shared with the MSB-first stream and the last sample is the tail zero; single channel clears lsb
							r_nxt.lsb   = TWO_CHANNEL ? {r_r.lsb[7:1], r_r.msb[0]}
							                          : 8'h00;
							r_nxt.sel_n = 1'b1;
							r_nxt.sclk  = 1'b0;
							r_nxt.div   = 5'h00;
							r_nxt.st    = HST_GAP;
						end
					end
				end
			end
			HST_GAP: begin
				// Select stays high long enough to clear the converter
				if (tick) begin
					r_nxt.mcnt = r_r.mcnt + 2'h1;
					if (r_r.mcnt[0]) begin
						r_nxt.done = 1'b1;
						r_nxt.st   = HST_IDLE;
					end
				end
			end
			default: begin
				r_nxt.st = HST_IDLE;
			end
		endcase
	end

	// State register with clock enable
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r_r <= '{st: HST_IDLE, sel_n: 1'b1, default: '0};
		end else if (clk_en) begin
			r_r <= r_nxt;
		end
	end

	// ==========================================
	// Outputs
	assign link.sclk           = r_r.sclk;
	assign link.sel_n          = r_r.sel_n;
	assign link.serial_in_line = r_r.din;
	assign req_ready           = (r_r.st == HST_IDLE);
	assign rsp_valid           = r_r.done;
	assign rsp_msb             = r_r.msb;
	assign rsp_lsb             = r_r.lsb;
endmodule

// file: dv/sar_link_checker.sv
// Concurrent checks on the serial link between host and converter
`timescale 1ns/10ps
module sar_link_checker #(
	parameter bit TWO_CHANNEL = 1'b1   // Converter variant under watch
) (
	// System
	input wire logic clk,
	input wire logic resetn,
	// Link
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic serial_in_line,
	input wire logic dout_o,
	input wire logic dout_oe,
	input wire logic dout_line
);
	// ==========================================
	// Helper logic
	localparam int FIRST_LOW = TWO_CHANNEL ? 16 : 9;   // Serial fall that ends result bits
	logic       sclk_q;     // Serial clock one cycle ago
	logic [4:0] fall_cnt;   // Serial falls since the output was enabled

	// Count serial falls while the converter drives, saturating
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_q   <= 1'b0;
			fall_cnt <= 5'h00;
		end else begin
			sclk_q <= sclk;
			if (!dout_oe) begin
				fall_cnt <= 5'h00;
			end else if (sclk_q && !sclk && fall_cnt != 5'h1f) begin
				fall_cnt <= fall_cnt + 5'h01;
			end
		end
	end

	// ==========================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_release_idle; sel_n [*2] |-> !dout_oe; endproperty
	property p_first_zero; $rose(dout_oe) |-> !dout_o && !$past(sclk) && $past(sclk, 2); endproperty
	property p_fall_launch;
		dout_oe && $past(dout_oe) && !$past(sel_n) && $changed(dout_o) |->
			!$past(sclk) && $past(sclk, 2);
	endproperty
	property p_hold_drive; dout_oe && !sel_n |=> dout_oe; endproperty
	property p_bit_count; $rose(sel_n) |-> fall_cnt >= FIRST_LOW - 1; endproperty
	property p_tail_low; dout_oe && fall_cnt >= FIRST_LOW |-> !dout_line; endproperty
	property p_host_hold; $rose(sel_n) |-> $past(dout_oe); endproperty
	property p_gap_len; $rose(sel_n) |-> sel_n [*4]; endproperty
	property p_addr_quiet; $fell(sel_n) |-> !dout_oe [*8]; endproperty

	a_release_idle: assert property (p_release_idle)
		else $error("Output driven while deselected");
	a_first_zero: assert property (p_first_zero)
		else $error("Output enable not at serial fall with a zero");
	a_fall_launch: assert property (p_fall_launch)
		else $error("Output changed away from a serial fall");
	a_hold_drive: assert property (p_hold_drive)
		else $error("Output released while selected");
	a_bit_count: assert property (p_bit_count)
		else $error("Frame closed before all result bits");
	a_tail_low: assert property (p_tail_low)
		else $error("Output not low after last result bit");
	a_host_hold: assert property (p_host_hold)
		else $error("Select raised before readout");
	a_gap_len: assert property (p_gap_len)
		else $error("Select high time too short");
	a_addr_quiet: assert property (p_addr_quiet)
		else $error("Output driven during addressing");

	// Main scenarios reached
	c_frame: cover property ($rose(dout_oe));
	c_tail: cover property (fall_cnt == FIRST_LOW);
	c_start: cover property (!sel_n && $rose(serial_in_line));
endmodule

// file: dv/tb_top.sv
// Self-checking bench joining the host and converter ends over the link
`timescale 1ns/10ps
module tb_top;
	import sar_link_pkg::*;
	// ==========================================
	// Rows and signals
	typedef struct packed {
		logic [1:0] mux;   // Mode then channel
		logic [7:0] a;     // Channel 0 level
		logic [7:0] b;     // Channel 1 level
	} row_s;
	localparam int NROWS   = 8;
	localparam int MAX_CYC = 6000;   // Ceiling for the whole run
	row_s rows [NROWS] = '{
		'{2'b10, 8'ha5, 8'h3c},
		'{2'b11, 8'ha5, 8'h3c},
		'{2'b00, 8'ha5, 8'h3c},
		'{2'b01, 8'ha5, 8'h3c},
		'{2'b10, 8'hff, 8'h00},
		'{2'b11, 8'h00, 8'hff},
		'{2'b00, 8'h80, 8'h80},
		'{2'b01, 8'h01, 8'hff}};
	logic       clk, resetn, clk_en, req_valid, req_ready, rsp_valid, busy;
	logic [7:0] ch0_level, ch1_level, rsp_msb, rsp_lsb, last_result;
	logic [1:0] req_mux, mux_cfg;
	int         miscompares, tests_run, cycles;

	// ==========================================
	// Design ends and checker
	sar_link_if u_sar_link_if ();
	sar_adc_seq u_sar_adc_seq (.clk(clk), .resetn(resetn), .clk_en(clk_en),
		.link(u_sar_link_if), .ch0_level(ch0_level), .ch1_level(ch1_level),
		.busy(busy), .last_result(last_result), .mux_cfg(mux_cfg));
	sar_host_ctrl u_sar_host_ctrl (.clk(clk), .resetn(resetn), .clk_en(clk_en),
		.req_valid(req_valid), .req_mux(req_mux), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_msb(rsp_msb), .rsp_lsb(rsp_lsb), .link(u_sar_link_if));
	sar_link_checker u_sar_link_checker (.clk(clk), .resetn(resetn),
		.sclk(u_sar_link_if.sclk), .sel_n(u_sar_link_if.sel_n),
		.serial_in_line(u_sar_link_if.serial_in_line), .dout_o(u_sar_link_if.dout_o),
		.dout_oe(u_sar_link_if.dout_oe), .dout_line(u_sar_link_if.dout_line));

	// ==========================================
	// Helpers
	always #4 clk = ~clk;

	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Result the converter should give for a row
	function automatic logic [7:0] expect_res(input row_s r);
		case (r.mux)
			2'b10: return r.a;
			2'b11: return r.b;
			2'b00: return (r.a > r.b) ? r.a - r.b : 8'h00;
			default: return (r.b > r.a) ? r.b - r.a : 8'h00;
		endcase
	endfunction

	// One request, then wait for and check its answer
	task automatic run_one(input row_s r);
		logic [7:0] e;
		e = expect_res(r);
		@(posedge clk);
		#1;
		ch0_level = r.a;
		ch1_level = r.b;
		req_mux   = r.mux;
		req_valid = 1'b1;
		// Hold the request until an edge at which ready stands high
		while (req_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1 req_valid = 1'b0;
		// Assignment is final once the converter drives its leading zero
		while (u_sar_link_if.dout_oe !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		check({6'h00, mux_cfg}, {6'h00, r.mux});
		// Answer pulse stands one cycle; look at it off the edge
		do begin
			@(posedge clk);
			#1;
		end while (rsp_valid !== 1'b1);
		check(rsp_msb, e);
		check(rsp_lsb, e);
		check(last_result, e);
		check({6'h00, mux_cfg}, 8'h00);
	endtask

	// Closing report
	task automatic conclude();
		$display("counts: %0d compares, %0d mismatches", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == MAX_CYC) begin
			miscompares++;
			$display("[ERR] %0t run ceiling reached", $time);
			conclude();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		clk_en = 1'b1;
		ch0_level = 8'h00;
		ch1_level = 8'h00;
		req_valid = 1'b0;
		req_mux = 2'b00;
		repeat (2) @(posedge clk);
		#1 resetn = 1'b1;
		check({7'h00, u_sar_link_if.sel_n}, 8'h01);
		check({7'h00, u_sar_link_if.dout_oe}, 8'h00);
		$display("reset test done");
		for (int i = 0; i < NROWS; i++) begin
			run_one(rows[i]);
			$display("row %0d done", i);
		end
		// Abort a frame midway by reset, then run a clean frame
		@(posedge clk);
		#1 req_valid = 1'b1;
		@(posedge clk);
		#1 req_valid = 1'b0;
		repeat (60) @(posedge clk);
		#1 resetn = 1'b0;
		@(posedge clk);
		#1;
		check({7'h00, u_sar_link_if.sel_n}, 8'h01);
		check({7'h00, u_sar_link_if.dout_oe}, 8'h00);
		resetn = 1'b1;
		run_one(rows[2]);
		$display("abort test done");
		conclude();
	end
endmodule
